// File: bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta     <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : bit_sync
`default_nettype wire

// File: reg_memory.sv
// register ram with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module reg_memory #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // clock
  input  wire logic              clk,
  // write port
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // read port
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  if (ADDR_W < 1 || DATA_W < 1)
  begin : bad_size
    $error("reg_memory: widths must be positive");
  end

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : reg_memory
`default_nettype wire

// File: ssi_master.sv
// serial master model that clocks frames and collects returned bits
`timescale 1ns/1ps
`default_nettype none
module ssi_master (
  // link pins
  input  wire logic sdo,
  output logic      sclk
);
  logic [31:0] rx;
  initial sclk = 1'b1;
  // clock idles high outside frames; one fall, then n rising edges
  task automatic frame(input int n);
    rx = '0;
    sclk = 1'b0;
    #32;
    repeat (n)
    begin
      sclk = 1'b1;
      #31;
      rx = {rx[30:0], sdo};
      #1;
      sclk = 1'b0;
      #32;
    end
    sclk = 1'b1;
  endtask : frame
endmodule : ssi_master
`default_nettype wire

// File: ssi_status_otp_control.sv
// ssi output, error status, register protection and otp programming control
`timescale 1ns/1ps
`default_nettype none
module ssi_status_otp_control
  import ssi_status_pkg::*;
#(
  parameter int HOLD_CYCLES = ERR_HOLD_CYCLES,
  parameter int POS_W       = POS_BITS
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // register channel from the protocol framing
  input  wire ssi_status_pkg::reg_req_t reg_req,
  output ssi_status_pkg::reg_rsp_t      reg_rsp,
  // ssi link pins
  input  wire logic                     serial_clock_in,
  output logic                          serial_data_out,
  // sensor side
  input  wire logic [POS_W-1:0]         position,
  input  wire logic                     position_valid,
  input  wire logic                     position_request,
  input  wire logic                     amplitude_high,
  input  wire logic                     amplitude_low,
  // programming
  input  wire logic                     programming_supply_high,
  output logic                          high_read_current,
  output logic                          zap_burn,
  // open-drain error pin
  input  wire logic                     error_pin_in,
  output logic                          error_out_n,
  output logic                          error_out_n_oe,
  output logic                          error_pullup_enable,
  // mode and flag
  output logic                          ssi_mode,
  output logic                          error_flag_n
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam int TO_W   = $clog2(LINK_TIMEOUT_CYCLES + 1);
  localparam int PC_W   = $clog2(PROG_CYCLES + 1);

  if (HOLD_CYCLES < 1 || POS_W != POS_BITS)
  begin : bad_param
    $error("ssi_status_otp_control: unsupported parameter value");
  end

  // -----------------------------------------------------------------
  // decoding
  // -----------------------------------------------------------------
  function automatic logic [POS_BITS-1:0] to_gray(input logic [POS_BITS-1:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic reg_writable(input logic [6:0] a, input logic prot);
    if (prot)
      return (a == ADDR_PORT) || (a == ADDR_TIMEOUT_CONFIG);
    else if (a <= ADDR_ZAP_TEST_CONFIG)
      return 1'b1;
    else if (a == ADDR_PORT)
      return 1'b1;
    else if (a >= ADDR_OEM_FIRST)
      return 1'b1;
    else
      return 1'b0;
  endfunction : reg_writable

  function automatic logic reg_readable(input logic [6:0] a, input logic prot);
    if (prot)
      return (a == ADDR_PROFILE_ID) || (a >= ADDR_PORT);
    else
      return 1'b1;
  endfunction : reg_readable

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       sclk_s;
  logic       supply_s;
  logic       err_pin_s;
  logic       sclk_prev;
  logic       sclk_rise;
  logic       sclk_fall;

  bit_sync #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({error_pin_in, programming_supply_high, serial_clock_in}),
    .sync_out (pins_sync)
  );

  assign sclk_s    = pins_sync[0];
  assign supply_s  = pins_sync[1];
  assign err_pin_s = pins_sync[2];
  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sclk_prev <= 1'b1;
    else
      sclk_prev <= sclk_s;
  end

  // -----------------------------------------------------------------
  // control bits
  // -----------------------------------------------------------------
  logic        pullup_disable;
  logic        protocol_select;
  logic        config_protect;
  logic        program_start;
  logic [2:0]  test_select;
  logic        wr_ok;
  logic        rd_ok;
  logic        req_ok;
  logic        wr_take;
  prog_state_t prog_state;
  logic        prog_busy;

  assign prog_busy = prog_state != PROG_IDLE;
  assign wr_ok     = reg_writable(reg_req.addr, config_protect);
  assign rd_ok     = reg_readable(reg_req.addr, config_protect);
  assign req_ok    = !ssi_mode && !prog_busy && (reg_req.write ? wr_ok : rd_ok);
  assign wr_take   = reg_req.req && reg_req.write && req_ok;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pullup_disable    <= RESET_CONTROL_BIT;
      protocol_select   <= RESET_CONTROL_BIT;
      config_protect    <= RESET_CONTROL_BIT;
      high_read_current <= RESET_CONTROL_BIT;
      program_start     <= RESET_CONTROL_BIT;
      test_select       <= RESET_TEST_SELECT;
    end
    else
    begin
      if (wr_take && reg_req.addr == ADDR_OUTPUT_PULLUP_CONFIG)
        pullup_disable <= reg_req.wdata[PULLUP_DISABLE_BIT];
      if (wr_take && reg_req.addr == ADDR_PROTOCOL_PROTECT_CONFIG)
      begin
        protocol_select <= reg_req.wdata[PROTOCOL_SELECT_BIT];
        config_protect  <= reg_req.wdata[CONFIG_PROTECT_BIT];
      end
      if (wr_take && reg_req.addr == ADDR_ZAP_TEST_CONFIG)
      begin
        high_read_current <= reg_req.wdata[HIGH_READ_CURRENT_BIT];
        test_select       <= reg_req.wdata[TEST_SELECT_MSB:TEST_SELECT_LSB];
        program_start     <= reg_req.wdata[PROGRAM_START_BIT];
      end
      else if (prog_state == PROG_END)
        program_start <= 1'b0;
    end
  end

  assign error_pullup_enable = ~pullup_disable;

  // -----------------------------------------------------------------
  // ssi frame engine
  // -----------------------------------------------------------------
  logic                     link_busy;
  logic [SSI_WORD_BITS-1:0] ssi_word;
  logic [3:0]               bit_idx;
  logic [TO_W-1:0]          idle_cnt;
  logic                     frame_start;
  logic                     timed_out;

  assign frame_start = !link_busy && ssi_mode && sclk_fall;
  assign timed_out   = idle_cnt == TO_W'(LINK_TIMEOUT_CYCLES - 1);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ssi_mode <= RESET_CONTROL_BIT;
    else if (!link_busy)
      ssi_mode <= protocol_select && !supply_s;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      idle_cnt <= '0;
    else if (!link_busy || sclk_rise || sclk_fall)
      idle_cnt <= '0;
    else if (!timed_out)
      idle_cnt <= idle_cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link_busy <= 1'b0;
      ssi_word  <= '0;
      bit_idx   <= '0;
    end
    else if (frame_start)
    begin
      link_busy <= 1'b1;
      ssi_word  <= {to_gray(position), 1'b0};
      bit_idx   <= '0;
    end
    else if (link_busy && timed_out && !sclk_rise && !sclk_fall)
      link_busy <= 1'b0;
    else if (link_busy && sclk_rise)
    begin
      if (bit_idx == 4'(SSI_WORD_BITS))
        bit_idx <= '0;
      else
        bit_idx <= bit_idx + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      serial_data_out <= 1'b1;
    else if (!link_busy)
      serial_data_out <= 1'b1;
    else if (sclk_rise)
    begin
      if (bit_idx == 4'(SSI_WORD_BITS))
        serial_data_out <= 1'b0;
      else
        serial_data_out <= ssi_word[4'(SSI_WORD_BITS - 1) - bit_idx];
    end
  end

  // -----------------------------------------------------------------
  // register memory and answer pipeline
  // -----------------------------------------------------------------
  logic [PC_W-1:0] prog_cnt;
  logic [4:0]      copy_idx;
  logic            prog_pass;
  logic [7:0]      mem_q;
  logic [6:0]      mem_raddr;
  logic            mem_we;
  logic [6:0]      mem_waddr;
  logic [7:0]      mem_wdata;
  logic            pend;
  logic            pend_ok;
  logic            pend_write;
  logic [6:0]      pend_addr;
  logic [7:0]      next_rdata;
  logic            status_read;
  status_t         status;

  assign mem_raddr = prog_busy ? {3'h0, copy_idx[3:0]} : reg_req.addr;
  assign mem_we    = (prog_state == PROG_COPY && copy_idx != 5'h0) || wr_take;
  assign mem_waddr = prog_busy ? ADDR_ZAP_BASE + 7'(copy_idx - 5'h1) : reg_req.addr;
  assign mem_wdata = prog_busy ? mem_q : reg_req.wdata;

  reg_memory #(.ADDR_W(7), .DATA_W(8)) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_q)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend       <= 1'b0;
      pend_ok    <= 1'b0;
      pend_write <= 1'b0;
      pend_addr  <= '0;
    end
    else
    begin
      pend       <= reg_req.req;
      pend_ok    <= req_ok;
      pend_write <= reg_req.write;
      pend_addr  <= reg_req.addr;
    end
  end

  always_comb
  begin
    if (pend_addr == ADDR_ERROR_STATUS)
      next_rdata = status;
    else if (pend_addr == ADDR_PROFILE_ID)
      next_rdata = PROFILE_ID_VALUE;
    else if (pend_addr == ADDR_RESOLUTION)
      next_rdata = RESOLUTION_VALUE;
    else if (pend_addr == ADDR_ZAP_TEST_CONFIG)
    begin
      next_rdata                    = mem_q;
      next_rdata[PROGRAM_START_BIT] = program_start;
    end
    else
      next_rdata = mem_q;
  end

  assign status_read = pend && pend_ok && !pend_write && pend_addr == ADDR_ERROR_STATUS;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rsp <= '0;
    else
    begin
      reg_rsp.ack    <= pend;
      reg_rsp.denied <= pend && !pend_ok;
      reg_rsp.rdata  <= (pend && pend_ok && !pend_write) ? next_rdata : 8'h00;
    end
  end

  // -----------------------------------------------------------------
  // zap programming sequence
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prog_state <= PROG_IDLE;
      prog_cnt   <= '0;
      copy_idx   <= '0;
      prog_pass  <= 1'b0;
    end
    else
    begin
      case (prog_state)
        PROG_IDLE:
        begin
          prog_cnt <= '0;
          copy_idx <= '0;
          if (program_start)
          begin
            prog_state <= PROG_BURN;
            prog_pass  <= supply_s && test_select == 3'h0;
          end
        end
        PROG_BURN:
        begin
          prog_cnt <= prog_cnt + 1'b1;
          if (prog_cnt == PC_W'(PROG_CYCLES - 1))
            prog_state <= prog_pass ? PROG_COPY : PROG_END;
        end
        PROG_COPY:
        begin
          copy_idx <= copy_idx + 1'b1;
          if (copy_idx == 5'(ZAP_ENTRIES))
            prog_state <= PROG_END;
        end
        PROG_END:
          prog_state <= PROG_IDLE;
        default:
          prog_state <= PROG_IDLE;
      endcase
    end
  end

  assign zap_burn = prog_state == PROG_BURN;

  // -----------------------------------------------------------------
  // status register and error pin
  // -----------------------------------------------------------------
  logic            pin_cond;
  logic [HOLD_W-1:0] hold_cnt;
  logic [HOLD_W-1:0] next_hold;
  logic [2:0]      drive_hist;
  status_t         set_bits;

  always_comb
  begin
    set_bits                      = '0;
    set_bits.amplitude_high_error = amplitude_high;
    set_bits.amplitude_low_error  = amplitude_low;
    set_bits.program_fail         = prog_state == PROG_END && !prog_pass;
    set_bits.program_success      = prog_state == PROG_END && prog_pass;
    set_bits.startup_read_error   = !position_valid && (frame_start || position_request);
    set_bits.external_error       = !err_pin_s && !error_out_n_oe && drive_hist == 3'h0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status <= RESET_STATUS;
    else if (status_read)
      status <= set_bits;
    else
      status <= status | set_bits;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      error_flag_n <= 1'b1;
    else
      error_flag_n <= ~(status.amplitude_high_error | status.amplitude_low_error
                        | status.program_fail | status.startup_read_error
                        | status.external_error);
  end

  assign pin_cond  = amplitude_high || amplitude_low || status.program_fail;
  assign next_hold = pin_cond ? HOLD_W'(HOLD_CYCLES) :
                     (hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hold_cnt       <= '0;
      error_out_n_oe <= 1'b0;
      drive_hist     <= '0;
    end
    else
    begin
      hold_cnt       <= next_hold;
      error_out_n_oe <= pin_cond || next_hold != '0;
      drive_hist     <= {drive_hist[1:0], error_out_n_oe};
    end
  end

  assign error_out_n = 1'b0;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  gray_word_a: assert property (frame_start |=> ssi_word == {to_gray($past(position)), 1'b0})
    else $error("ssi word not gray coded position");
  ring_sep_a: assert property (link_busy && sclk_rise && bit_idx == 4'd13 |=> !serial_data_out)
    else $error("separator bit not zero");
  mode_boundary_a: assert property (link_busy |=> $stable(ssi_mode))
    else $error("protocol changed inside frame");
  ssi_refuse_a: assert property (reg_req.req && ssi_mode |=> ##1 reg_rsp.ack && reg_rsp.denied)
    else $error("register access not refused in ssi mode");
  protect_write_a: assert property (wr_take && config_protect
      |-> reg_req.addr == ADDR_PORT || reg_req.addr == ADDR_TIMEOUT_CONFIG)
    else $error("protected write accepted");
  err_pin_a: assert property (amplitude_high || amplitude_low |=> error_out_n_oe)
    else $error("error pin not driven");
  err_release_a: assert property (!pin_cond && hold_cnt == HOLD_W'(1) ##1 !pin_cond
      |=> !error_out_n_oe)
    else $error("error pin not released after hold");
  prog_result_a: assert property (prog_state == PROG_END
      |=> (prog_pass ? status.program_success : status.program_fail) && !program_start)
    else $error("programming result not recorded");
  status_clear_a: assert property (status_read && !amplitude_high && !amplitude_low
      |=> !status.amplitude_high_error && !status.amplitude_low_error)
    else $error("status not cleared by read");

  ring_wrap_c: cover property (link_busy && sclk_rise && bit_idx == 4'd13);
  prog_ok_c: cover property (prog_state == PROG_END && prog_pass);
  denied_c: cover property (reg_rsp.ack && reg_rsp.denied && config_protect);
  ext_err_c: cover property (set_bits.external_error);

endmodule : ssi_status_otp_control
`default_nettype wire

// File: ssi_status_pkg.sv
// shared constants, types and register map for the serial status block
package ssi_status_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ             = 200;
  localparam int LINK_TIMEOUT_US     = 20;
  localparam int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_US * CLK_MHZ;
  localparam int ERR_HOLD_MS         = 1;
  localparam int ERR_HOLD_CYCLES     = ERR_HOLD_MS * 1000 * CLK_MHZ;
  localparam int PROG_TIME_US        = 5;
  localparam int PROG_CYCLES         = PROG_TIME_US * CLK_MHZ;

  // -----------------------------------------------------------------
  // word formats
  // -----------------------------------------------------------------
  localparam int POS_BITS      = 12;
  localparam int SSI_WORD_BITS = 13;
  localparam int ZAP_ENTRIES   = 16;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [6:0] ADDR_OUTPUT_PULLUP_CONFIG    = 7'h04;
  localparam logic [6:0] ADDR_PROTOCOL_PROTECT_CONFIG = 7'h05;
  localparam logic [6:0] ADDR_ZAP_TEST_CONFIG         = 7'h0f;
  localparam logic [6:0] ADDR_ZAP_BASE                = 7'h10;
  localparam logic [6:0] ADDR_ZAP_LAST                = 7'h1f;
  localparam logic [6:0] ADDR_PROFILE_ID              = 7'h42;
  localparam logic [6:0] ADDR_RESOLUTION              = 7'h43;
  localparam logic [6:0] ADDR_PORT                    = 7'h75;
  localparam logic [6:0] ADDR_GAIN                    = 7'h76;
  localparam logic [6:0] ADDR_ERROR_STATUS            = 7'h77;
  localparam logic [6:0] ADDR_OEM_FIRST               = 7'h78;
  localparam logic [6:0] ADDR_TIMEOUT_CONFIG          = 7'h7c;
  localparam logic [6:0] ADDR_LAST                    = 7'h7f;

  localparam logic [7:0] PROFILE_ID_VALUE = 8'h2c;
  localparam logic [7:0] RESOLUTION_VALUE = 8'h0c;

  localparam int PULLUP_DISABLE_BIT    = 6;
  localparam int PROTOCOL_SELECT_BIT   = 7;
  localparam int CONFIG_PROTECT_BIT    = 6;
  localparam int HIGH_READ_CURRENT_BIT = 7;
  localparam int PROGRAM_START_BIT     = 6;
  localparam int TEST_SELECT_LSB       = 0;
  localparam int TEST_SELECT_MSB       = 2;

  localparam logic       RESET_CONTROL_BIT = 1'b0;
  localparam logic [2:0] RESET_TEST_SELECT = 3'h0;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reserved;
    logic       external_error;
    logic       startup_read_error;
    logic       program_success;
    logic       program_fail;
    logic       amplitude_low_error;
    logic       amplitude_high_error;
  } status_t;

  localparam status_t RESET_STATUS = '0;

  typedef struct packed {
    logic       req;
    logic       write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       ack;
    logic       denied;
    logic [7:0] rdata;
  } reg_rsp_t;

  typedef enum logic [1:0] {
    PROG_IDLE = 2'b00,
    PROG_BURN = 2'b01,
    PROG_COPY = 2'b10,
    PROG_END  = 2'b11
  } prog_state_t;

endpackage : ssi_status_pkg

// File: tb_top.sv
// self-checking testbench for the serial status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ssi_status_pkg::*;
  logic        clk = 0;
  logic        resetn = 0;
  logic        amp_hi = 0;
  logic        amp_lo = 0;
  logic        pvalid = 1;
  logic        preq = 0;
  logic        ext = 0;
  logic        sup = 0;
  logic [11:0] pos = 12'h0a5c;
  reg_req_t    req = '0;
  reg_rsp_t    rsp;
  logic        sclk, sdo, oe, pu, mode, flag_n, hrc, burn, drv;
  int          fails = 0;
  int          checked = 0;
  always #2.5 clk = ~clk;
  ssi_master i_ssi_master (.sdo(sdo), .sclk(sclk));
  ssi_status_otp_control #(.HOLD_CYCLES(50)) i_ssi_status_otp_control (
    .clk(clk), .resetn(resetn), .reg_req(req), .reg_rsp(rsp),
    .serial_clock_in(sclk), .serial_data_out(sdo), .position(pos),
    .position_valid(pvalid), .position_request(preq), .amplitude_high(amp_hi),
    .amplitude_low(amp_lo), .programming_supply_high(sup),
    .high_read_current(hrc), .zap_burn(burn), .error_pin_in(~oe & ~ext), .error_out_n(drv),
    .error_out_n_oe(oe), .error_pullup_enable(pu), .ssi_mode(mode),
    .error_flag_n(flag_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rst;
    @(posedge clk) resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk) #1;
  endtask : rst
  // one register access, answer waited for under a bound
  task automatic rw(input logic w, input logic [6:0] a, input logic [7:0] d,
                    input logic dn, input logic [7:0] e);
    int i;
    @(posedge clk) req <= '{1'b1, w, a, d};
    @(posedge clk) req.req <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk) #1;
      if (rsp.ack === 1'b1) break;
    end
    if (i == 4)
    begin
      chk("ack", 1, 0);
      results();
    end
    else
    begin
      chk("denied", dn, rsp.denied);
      chk("rdata", e, rsp.rdata);
    end
  endtask : rw
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_map;
    rst();
    chk("reset", 8'b1011_0000, {sdo, mode, flag_n, pu, oe, drv, hrc, burn});
    rw(1, 7'h04, 8'h40, 0, 8'h00);
    chk("pullup", 0, pu);
    rw(0, 7'h04, 8'h00, 0, 8'h40);
    rw(1, 7'h42, 8'h55, 1, 8'h00);
    rw(0, 7'h42, 8'h00, 0, 8'h2c);
    rw(1, 7'h10, 8'h01, 1, 8'h00);
    $display("map test done");
  endtask : t_map
  task automatic t_prot;
    rw(1, 7'h05, 8'h40, 0, 8'h00);
    rw(1, 7'h04, 8'h00, 1, 8'h00);
    rw(0, 7'h04, 8'h00, 1, 8'h00);
    rw(0, 7'h42, 8'h00, 0, 8'h2c);
    rw(1, 7'h75, 8'h03, 0, 8'h00);
    rw(0, 7'h75, 8'h00, 0, 8'h03);
    $display("protect test done");
  endtask : t_prot
  task automatic t_ssi;
    logic [11:0] g;
    g = pos ^ (pos >> 1);
    rst();
    rw(1, 7'h05, 8'h80, 0, 8'h00);
    chk("mode", 1, mode);
    rw(0, 7'h04, 8'h00, 1, 8'h00);
    i_ssi_master.frame(26);
    chk("word", {g, 2'b00, g}, i_ssi_master.rx[25:0]);
    repeat (4200) @(posedge clk);
    chk("idle", 1, sdo);
    @(posedge clk) sup <= 1'b1;
    repeat (4) @(posedge clk);
    chk("forced", 0, mode);
    rw(1, 7'h05, 8'h00, 0, 8'h00);
    @(posedge clk) sup <= 1'b0;
    $display("ssi test done");
  endtask : t_ssi
  task automatic t_err;
    rst();
    @(posedge clk);
    amp_hi <= 1'b1;
    amp_lo <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin", 1, oe);
    chk("flag", 0, flag_n);
    amp_hi <= 1'b0;
    amp_lo <= 1'b0;
    repeat (40) @(posedge clk);
    chk("hold", 1, oe);
    repeat (20) @(posedge clk);
    chk("release", 0, oe);
    rw(0, 7'h77, 8'h00, 0, 8'h03);
    repeat (2) @(posedge clk);
    chk("flag", 1, flag_n);
    pvalid <= 1'b0;
    preq   <= 1'b1;
    @(posedge clk) preq <= 1'b0;
    pvalid <= 1'b1;
    repeat (2) @(posedge clk);
    chk("flag", 0, flag_n);
    chk("pin", 0, oe);
    rw(0, 7'h77, 8'h00, 0, 8'h10);
    @(posedge clk) ext <= 1'b1;
    repeat (6) @(posedge clk);
    ext <= 1'b0;
    rw(0, 7'h77, 8'h00, 0, 8'h20);
    $display("error test done");
  endtask : t_err
  task automatic t_prog;
    rw(1, 7'h0f, 8'h40, 0, 8'h00);
    repeat (1100) @(posedge clk);
    chk("pin", 1, oe);
    rw(0, 7'h77, 8'h00, 0, 8'h04);
    rw(0, 7'h0f, 8'h00, 0, 8'h00);
    @(posedge clk) sup <= 1'b1;
    rw(1, 7'h00, 8'h5a, 0, 8'h00);
    rw(1, 7'h0f, 8'hc0, 0, 8'h00);
    chk("burn", 1, burn);
    chk("current", 1, hrc);
    repeat (1100) @(posedge clk);
    chk("burn", 0, burn);
    rw(0, 7'h77, 8'h00, 0, 8'h08);
    rw(0, 7'h10, 8'h00, 0, 8'h5a);
    rw(0, 7'h0f, 8'h00, 0, 8'h80);
    @(posedge clk) sup <= 1'b0;
    $display("program test done");
  endtask : t_prog
  initial
  begin
    t_map();
    t_prot();
    t_ssi();
    t_err();
    t_prog();
    results();
  end
endmodule : tb_top
`default_nettype wire
